// ---- dv/gpx_board.sv ----
`timescale 1ns/1ps
module gpx_board (
  // Pads as seen from the board
  input  wire logic [63:0] pin_out,
  input  wire logic [63:0] pin_oe,
  output logic      [63:0] pin_in,
  // Level the board drives where the chip does not
  input  wire logic [63:0] ext_val
);
  // -----------------------------
  // Pad resolution
  // -----------------------------
  // Chip driver wins; an open-drain low shows as 0
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule : gpx_board

// ---- dv/tb.sv ----
`timescale 1ns/1ps
module tb;
  // -----------------------------
  // Signals
  // -----------------------------
  logic              clk_sys, rst, reg_wr;
  logic [2:0]        reg_port;
  gpx_pkg::gpx_sel_t reg_sel;
  logic [7:0]        reg_wdata, reg_rdata, dv, ov, odv, hv, bv8, msk, r, bad;
  logic [63:0]       pin_in, pin_out, pin_oe, pin_hd, ext_val;
  logic [18:0]       pv;
  logic [15:0]       irq_rise_sel;
  logic [7:0]        irq_a, irq_c, irq_d;
  logic              stop_rec;
  logic [31:0]       bv;
  wire  [9:0]        rx;
  wire  [3:0]        spi_in;
  wire  [31:0]       irqv = {irq_d, irq_c, 8'h00, irq_a};
  int                err_count, num_checks, ci, cs;
  int                pins[5] = '{0, 16, 24, 8, 9};

  gpx_top gpx_top_i (
    .clk_sys(clk_sys), .rst(rst), .reg_port(reg_port), .reg_sel(reg_sel), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_high_drive(pin_hd), .timer0_in(rx[0]), .timer0_out(pv[0]),
    .uart_a_driver_en(pv[1]), .uart_a_clear_to_send(rx[1]), .uart_a_receive(rx[2]),
    .uart_a_transmit(pv[2]), .i2c_clk_in(rx[3]), .i2c_clk_drive_low(pv[3]),
    .i2c_data_in(rx[4]), .i2c_data_drive_low(pv[4]), .timer1_in(rx[5]), .timer1_out(pv[5]),
    .spi_in(spi_in), .spi_out(pv[9:6]), .spi_oe(pv[13:10]), .timer2_in(rx[6]),
    .timer2_out(pv[14]), .timer3_in(rx[7]), .timer3_out(pv[15]), .uart_b_driver_en(pv[16]),
    .uart_b_receive(rx[8]), .uart_b_transmit(pv[17]), .uart_b_clear_to_send(rx[9]),
    .wdt_osc_output(pv[18]), .irq_rise_sel(irq_rise_sel), .irq_port_a(irq_a),
    .irq_port_c(irq_c), .irq_port_d(irq_d), .stop_recover(stop_rec)
  );
  gpx_board gpx_board_i (.pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in), .ext_val(ext_val));

  // -----------------------------
  // Helpers
  // -----------------------------
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : wt

  // One register write, strobe held across one rising edge
  task automatic wr(input int p, input gpx_pkg::gpx_sel_t s, input logic [7:0] d);
    @(negedge clk_sys);
    reg_port  = 3'(p);
    reg_sel   = s;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask : wr

  task automatic sub(input int p, input logic [7:0] i, input logic [7:0] d);
    wr(p, gpx_pkg::GPX_SEL_ADDR_E, i);
    wr(p, gpx_pkg::GPX_SEL_CTL_E, d);
  endtask : sub

  task automatic rd(input int p, input gpx_pkg::gpx_sel_t s, output logic [7:0] d);
    @(negedge clk_sys);
    reg_port = 3'(p);
    reg_sel  = s;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask : rd

  // Move one pad and count event pulses over the next cycles
  task automatic tog(input int n, input logic v, output int c_irq, output int c_stop);
    @(negedge clk_sys);
    ext_val[n] = v;
    c_irq = 0;
    c_stop = 0;
    repeat (8) begin
      @(negedge clk_sys);
      if (irqv[n] === 1'b1) c_irq++;
      if (stop_rec === 1'b1) c_stop++;
    end
  endtask : tog

  // Port A and D single edge, port C any edge, others none
  function automatic int f_irq(int n, logic up);
    if (n == 16) return 1;
    if (n == 8 || n == 9) return 0;
    return int'(irq_rise_sel[(n == 24) ? 8 : 0] == up);
  endfunction : f_irq

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  // -----------------------------
  // Clock and watchdog
  // -----------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  initial begin
    #80000;
    err_count++;
    conclude();
  end

  // -----------------------------
  // Tests
  // -----------------------------
  initial begin
    void'($urandom(32'h2A07BCFC));
    rst          = 1'b1;
    reg_wr       = 1'b0;
    reg_port     = 3'h0;
    reg_sel      = gpx_pkg::GPX_SEL_ADDR_E;
    reg_wdata    = 8'h00;
    ext_val      = 64'h0;
    pv           = 19'h0;
    irq_rise_sel = 16'h0;
    wt(12);
    rst = 1'b0;
    wt(1);
    chk("rst_oe", 64'h0, pin_oe);
    $display("test reset done");
    // Plain ports: random direction, drain, drive, data
    for (int p = 0; p < 8; p++) begin
      msk = (p == 7) ? 8'h0F : 8'hFF;
      dv  = 8'($urandom);
      ov  = 8'($urandom);
      odv = 8'($urandom);
      hv  = 8'($urandom);
      bv8 = 8'($urandom);
      // Corners: pushing pin on port E, high input on port F, index 00 on even ports
      if (p == 4) {dv[0], odv[0]} = 2'b00;
      if (p == 5) {dv[0], bv8[0]} = 2'b11;
      bad = p[0] ? 8'($urandom_range(255, 6)) : 8'h00;
      wr(p, gpx_pkg::GPX_SEL_ADDR_E, 8'h01);
      rd(p, gpx_pkg::GPX_SEL_CTL_E, r);
      chk("dir_reset", 64'(msk), 64'(r));
      wr(p, gpx_pkg::GPX_SEL_CTL_E, dv);
      sub(p, 8'h03, odv);
      sub(p, 8'h04, hv);
      wr(p, gpx_pkg::GPX_SEL_OUT_E, ov);
      sub(p, bad, ~dv);
      ext_val[p*8 +: 8] = bv8;
      wt(4);
      chk("gpio_oe", 64'(msk & ~dv & ~(odv & ov)), 64'(pin_oe[p*8 +: 8]));
      chk("gpio_out", 64'(msk & ~dv & ov & ~odv), 64'(pin_out[p*8 +: 8] & pin_oe[p*8 +: 8]));
      chk("high_drive", 64'(msk & hv), 64'(pin_hd[p*8 +: 8]));
      rd(p, gpx_pkg::GPX_SEL_IN_E, r);
      chk("in_data", 64'(msk & dv & bv8), 64'(r & (dv | ~msk)));
      rd(p, gpx_pkg::GPX_SEL_OUT_E, r);
      chk("out_data", 64'(msk & ov), 64'(r));
    end
    $display("test gpio done");
    // Alternate functions on A, C, D; direction bits left at input
    for (int p = 0; p < 4; p++) begin
      if (p == 1) continue;
      sub(p, 8'h01, 8'hFF);
      sub(p, 8'h03, 8'h00);
      sub(p, 8'h02, (p == 3) ? 8'hFB : 8'hFF);
    end
    pv = 19'($urandom);
    bv = $urandom;
    ext_val[31:0] = bv;
    wt(5);
    chk("alt_oe", {8'hAA, 1'b1, 1'b0, pv[13:10], 2'b10, pv[4:3], 6'b100110},
        {pin_oe[31:16], pin_oe[7:0]});
    chk("alt_out", {pv[18], 1'b0, pv[17], 1'b0, pv[16], 1'b0, pv[15], 1'b0, pv[14], 1'b0,
        pv[9:6] & pv[13:10], pv[5], 3'b000, pv[2], 2'b00, pv[1:0], 1'b0},
        {pin_out[31:16] & pin_oe[31:16], pin_out[7:0] & pin_oe[7:0]});
    chk("alt_in", {bv[30], bv[28], bv[24], bv[22], bv[16], bv[7] & ~pv[4], bv[6] & ~pv[3],
        bv[4], bv[3], bv[0]}, 64'(rx));
    chk("spi_in", 64'((pv[9:6] & pv[13:10]) | (bv[21:18] & ~pv[13:10])), 64'(spi_in));
    $display("test alternate done");
    // Pin events and wake
    sub(1, 8'h01, 8'hFF);
    sub(1, 8'h05, 8'h01);
    // Port A bit 0 always on rising edges, so its falling edge must stay quiet
    irq_rise_sel = 16'($urandom) | 16'h0001;
    ext_val[31:0] = 32'h0;
    wt(6);
    for (int k = 0; k < 5; k++) begin
      for (int u = 1; u >= 0; u--) begin
        tog(pins[k], u[0], ci, cs);
        chk("irq_count", 64'(f_irq(pins[k], u[0])), 64'(ci));
        chk("wake_count", 64'(pins[k] == 8), 64'(cs));
      end
    end
    $display("test events done");
    conclude();
  end
endmodule : tb

// ---- hdl/gpx_params.svh ----
`ifndef GPX_PARAMS_SVH
`define GPX_PARAMS_SVH

// Port count and widths
`define GPX_NPORTS      8
`define GPX_NPINS       64
`define GPX_PORT_H      3'h7
`define GPX_PORT_H_MASK 8'h0F
// Register select codes on the register port
`define GPX_SEL_ADDR    2'h0
`define GPX_SEL_CTL     2'h1
`define GPX_SEL_IN      2'h2
`define GPX_SEL_OUT     2'h3
// Sub-register indices behind the control window
`define GPX_SUB_DIR     8'h01
`define GPX_SUB_ALT     8'h02
`define GPX_SUB_OD      8'h03
`define GPX_SUB_HD      8'h04
`define GPX_SUB_WAKE    8'h05
// Reset values
`define GPX_ADDR_RST    8'h00
`define GPX_DIR_RST     8'hFF
`define GPX_ALT_RST     8'h00
`define GPX_OD_RST      8'h00
`define GPX_HD_RST      8'h00
`define GPX_WAKE_RST    8'h00
`define GPX_OUT_RST     8'h00
// Port A pins that turn open-drain with their alternate function
`define GPX_I2C_OD_MASK 8'hC0
`endif

// ---- hdl/gpx_pkg.sv ----
package gpx_pkg;
  // One port's worth of bits
  typedef logic [7:0] gpx_byte_t;
  // Register select on the register port
  typedef enum logic [1:0] {
    GPX_SEL_ADDR_E = 2'h0,
    GPX_SEL_CTL_E  = 2'h1,
    GPX_SEL_IN_E   = 2'h2,
    GPX_SEL_OUT_E  = 2'h3
  } gpx_sel_t;
endpackage : gpx_pkg

// ---- hdl/gpx_top.sv ----
`timescale 1ns/1ps
`include "gpx_params.svh"
module gpx_top (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // Register port
  input  wire logic [2:0]        reg_port,
  input  wire gpx_pkg::gpx_sel_t reg_sel,
  input  wire logic              reg_wr,
  input  wire logic [7:0]        reg_wdata,
  output logic      [7:0]        reg_rdata,
  // Pads, port A in bits 7:0 up to port H in bits 59:56
  input  wire logic [63:0]       pin_in,
  output logic      [63:0]       pin_out,
  output logic      [63:0]       pin_oe,
  output logic      [63:0]       pin_high_drive,
  // Port A peripherals
  output logic                   timer0_in,
  input  wire logic              timer0_out,
  input  wire logic              uart_a_driver_en,
  output logic                   uart_a_clear_to_send,
  output logic                   uart_a_receive,
  input  wire logic              uart_a_transmit,
  output logic                   i2c_clk_in,
  input  wire logic              i2c_clk_drive_low,
  output logic                   i2c_data_in,
  input  wire logic              i2c_data_drive_low,
  // Port C peripherals
  output logic                   timer1_in,
  input  wire logic              timer1_out,
  output logic      [3:0]        spi_in,
  input  wire logic [3:0]        spi_out,
  input  wire logic [3:0]        spi_oe,
  output logic                   timer2_in,
  input  wire logic              timer2_out,
  // Port D peripherals
  output logic                   timer3_in,
  input  wire logic              timer3_out,
  input  wire logic              uart_b_driver_en,
  output logic                   uart_b_receive,
  input  wire logic              uart_b_transmit,
  output logic                   uart_b_clear_to_send,
  input  wire logic              wdt_osc_output,
  // Pin events
  input  wire logic [15:0]       irq_rise_sel,
  output logic      [7:0]        irq_port_a,
  output logic      [7:0]        irq_port_c,
  output logic      [7:0]        irq_port_d,
  output logic                   stop_recover
);

  //--------------------------------------------------------------------
  // Storage
  //--------------------------------------------------------------------
  gpx_pkg::gpx_byte_t addr_q [8];
  gpx_pkg::gpx_byte_t dir_q  [8];
  gpx_pkg::gpx_byte_t alt_q  [8];
  gpx_pkg::gpx_byte_t od_q   [8];
  gpx_pkg::gpx_byte_t hd_q   [8];
  gpx_pkg::gpx_byte_t wake_q [8];
  gpx_pkg::gpx_byte_t out_q  [8];
  gpx_pkg::gpx_byte_t in_q   [8];
  logic [63:0] dir_all, alt_all, od_all, hd_all, wake_all, out_all, valid_all;
  logic [63:0] sync1_q, sync2_q, sync3_q;
  logic [63:0] alt_out, alt_oe;

  //--------------------------------------------------------------------
  // Input synchroniser and edge history
  //--------------------------------------------------------------------
  // Chain keeps tracking the pads through reset, so a pin resting high gives no false edge
  always_ff @(posedge clk_sys) begin
    sync1_q <= pin_in;
    sync2_q <= sync1_q;
    sync3_q <= sync2_q;
  end

  //--------------------------------------------------------------------
  // Per-port registers
  //--------------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < `GPX_NPORTS; p++) begin : g_port
      localparam logic [7:0] MASK = (p == 7) ? `GPX_PORT_H_MASK : 8'hFF;
      logic sel_p, wr_addr, wr_ctl, wr_out;
      logic [7:0] wd;
      logic [7:0] sample;
      // Write decode for this port
      assign sel_p   = reg_wr && (reg_port == 3'(p));
      assign wd      = reg_wdata & MASK;
      assign wr_addr = sel_p && (reg_sel == gpx_pkg::GPX_SEL_ADDR_E);
      assign wr_ctl  = sel_p && (reg_sel == gpx_pkg::GPX_SEL_CTL_E);
      assign wr_out  = sel_p && (reg_sel == gpx_pkg::GPX_SEL_OUT_E);
      assign sample  = (dir_q[p] | alt_q[p]) & MASK;
      // Index and control window, indices outside 01 to 05 ignored
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          addr_q[p] <= `GPX_ADDR_RST;
          dir_q[p]  <= `GPX_DIR_RST & MASK;
          alt_q[p]  <= `GPX_ALT_RST;
          od_q[p]   <= `GPX_OD_RST;
          hd_q[p]   <= `GPX_HD_RST;
          wake_q[p] <= `GPX_WAKE_RST;
        end else begin
          if (wr_addr) addr_q[p] <= reg_wdata;
          if (wr_ctl && addr_q[p] == `GPX_SUB_DIR)  dir_q[p]  <= wd;
          if (wr_ctl && addr_q[p] == `GPX_SUB_ALT)  alt_q[p]  <= wd;
          if (wr_ctl && addr_q[p] == `GPX_SUB_OD)   od_q[p]   <= wd;
          if (wr_ctl && addr_q[p] == `GPX_SUB_HD)   hd_q[p]   <= wd;
          if (wr_ctl && addr_q[p] == `GPX_SUB_WAKE) wake_q[p] <= wd;
        end
      end
      // Output and input data
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          out_q[p] <= `GPX_OUT_RST;
          in_q[p]  <= 8'h00;
        end else begin
          if (wr_out) out_q[p] <= wd;
          in_q[p] <= (in_q[p] & ~sample) | (sync2_q[p*8 +: 8] & sample);
        end
      end
      // Flatten
      assign dir_all[p*8 +: 8]   = dir_q[p];
      assign alt_all[p*8 +: 8]   = alt_q[p];
      assign od_all[p*8 +: 8]    = od_q[p];
      assign hd_all[p*8 +: 8]    = hd_q[p];
      assign wake_all[p*8 +: 8]  = wake_q[p];
      assign out_all[p*8 +: 8]   = out_q[p];
      assign valid_all[p*8 +: 8] = MASK;
    end
  endgenerate

  //--------------------------------------------------------------------
  // Alternate function map
  //--------------------------------------------------------------------
  // Port A, C, D outputs and enables; other ports have none
  assign alt_out[7:0]   = {2'b00, uart_a_transmit, 2'b00, uart_a_driver_en,
                           timer0_out, 1'b0};
  assign alt_oe[7:0]    = {i2c_data_drive_low, i2c_clk_drive_low, 1'b1, 2'b00,
                           1'b1, 1'b1, 1'b0};
  assign alt_out[15:8]  = 8'h00;
  assign alt_oe[15:8]   = 8'h00;
  assign alt_out[23:16] = {timer2_out, 1'b0, spi_out, timer1_out, 1'b0};
  assign alt_oe[23:16]  = {1'b1, 1'b0, spi_oe, 1'b1, 1'b0};
  assign alt_out[31:24] = {wdt_osc_output, 1'b0, uart_b_transmit, 1'b0,
                           uart_b_driver_en, 1'b0, timer3_out, 1'b0};
  assign alt_oe[31:24]  = 8'hAA;
  assign alt_out[63:32] = 32'h0;
  assign alt_oe[63:32]  = 32'h0;

  //--------------------------------------------------------------------
  // Pad drive
  //--------------------------------------------------------------------
  logic [63:0] drv_val, drv_en, od_eff, oe_d, out_d;
  assign drv_val = (alt_all & alt_out) | (~alt_all & out_all);
  assign drv_en  = (alt_all & alt_oe) | (~alt_all & ~dir_all);
  assign od_eff  = od_all | {56'h0, alt_all[7:0] & `GPX_I2C_OD_MASK};
  assign oe_d    = drv_en & (~od_eff | ~drv_val) & valid_all;
  assign out_d   = drv_val & ~od_eff & valid_all;

  // Registered pad outputs
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_out        <= 64'h0;
      pin_oe         <= 64'h0;
      pin_high_drive <= 64'h0;
    end else begin
      pin_out        <= out_d;
      pin_oe         <= oe_d;
      pin_high_drive <= hd_all & valid_all;
    end
  end

  //--------------------------------------------------------------------
  // Peripheral inputs, events and read-back
  //--------------------------------------------------------------------
  logic [63:0] rise, fall, chg;
  logic [7:0]  sub_rd, rd_d;
  assign rise = sync2_q & ~sync3_q;
  assign fall = ~sync2_q & sync3_q;
  assign chg  = sync2_q ^ sync3_q;
  assign sub_rd = (addr_q[reg_port] == `GPX_SUB_DIR)  ? dir_q[reg_port]  :
                  (addr_q[reg_port] == `GPX_SUB_ALT)  ? alt_q[reg_port]  :
                  (addr_q[reg_port] == `GPX_SUB_OD)   ? od_q[reg_port]   :
                  (addr_q[reg_port] == `GPX_SUB_HD)   ? hd_q[reg_port]   :
                  (addr_q[reg_port] == `GPX_SUB_WAKE) ? wake_q[reg_port] : 8'h00;
  assign rd_d = (reg_sel == gpx_pkg::GPX_SEL_ADDR_E) ? addr_q[reg_port] :
                (reg_sel == gpx_pkg::GPX_SEL_CTL_E)  ? sub_rd :
                (reg_sel == gpx_pkg::GPX_SEL_IN_E)   ? in_q[reg_port] : out_q[reg_port];

  // Event pulses, wake recovery and read data
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_port_a   <= 8'h00;
      irq_port_c   <= 8'h00;
      irq_port_d   <= 8'h00;
      stop_recover <= 1'b0;
      reg_rdata    <= 8'h00;
    end else begin
      irq_port_a   <= (rise[7:0] & irq_rise_sel[7:0]) | (fall[7:0] & ~irq_rise_sel[7:0]);
      irq_port_d   <= (rise[31:24] & irq_rise_sel[15:8])
                    | (fall[31:24] & ~irq_rise_sel[15:8]);
      irq_port_c   <= chg[23:16];
      stop_recover <= |(chg & wake_all & valid_all);
      reg_rdata    <= rd_d;
    end
  end

  // Synchronised pins to peripherals
  assign timer0_in            = sync2_q[0];
  assign uart_a_clear_to_send = sync2_q[3];
  assign uart_a_receive       = sync2_q[4];
  assign i2c_clk_in           = sync2_q[6];
  assign i2c_data_in          = sync2_q[7];
  assign timer1_in            = sync2_q[16];
  assign spi_in               = sync2_q[21:18];
  assign timer2_in            = sync2_q[22];
  assign timer3_in            = sync2_q[24];
  assign uart_b_receive       = sync2_q[28];
  assign uart_b_clear_to_send = sync2_q[30];

  //--------------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  gpio_drive_a: assert property (
    (!alt_all[32] && !dir_all[32] && !od_all[32]) |=> pin_oe[32] && pin_out[32] == $past(out_all[32]))
    else $error("output pin not driven from output data");
  input_tristate_a: assert property (
    (dir_all[33] && !alt_all[33]) |=> !pin_oe[33])
    else $error("input pin is driven");
  alt_direction_a: assert property (
    (alt_all[1] && dir_all[1] && !od_all[1]) |=> pin_oe[1] && pin_out[1] == $past(timer0_out))
    else $error("alternate output not driven by timer");
  i2c_open_drain_a: assert property (
    alt_all[6] |=> !pin_out[6] && pin_oe[6] == $past(i2c_clk_drive_low))
    else $error("i2c pin not open-drain");
  port_h_upper_a: assert property (
    pin_oe[63:60] == 4'h0 && dir_q[7][7:4] == 4'h0)
    else $error("port h upper bits active");
  dir_write_a: assert property (
    (reg_wr && reg_sel == gpx_pkg::GPX_SEL_CTL_E && reg_port == 3'h0 && addr_q[0] == `GPX_SUB_DIR)
    |=> dir_q[0] == $past(reg_wdata))
    else $error("direction sub-register not written");
  null_index_a: assert property (
    (reg_wr && reg_sel == gpx_pkg::GPX_SEL_CTL_E && reg_port == 3'h0 && addr_q[0] == 8'h00)
    |=> dir_q[0] == $past(dir_q[0]) && alt_q[0] == $past(alt_q[0]))
    else $error("index zero changed configuration");
  sync_latency_a: assert property (
    (pin_in[40] && dir_all[40] && !alt_all[40])[*3] |=> in_q[5][0])
    else $error("input data not sampled after synchroniser");
  any_edge_a: assert property (
    (pin_in[16] != $past(pin_in[16])) |-> ##3 irq_port_c[0])
    else $error("port c transition missed");
  one_edge_a: assert property (
    ($fell(pin_in[0]) && irq_rise_sel[0]) ##1 irq_rise_sel[0][*2] |=> !irq_port_a[0])
    else $error("falling edge raised rising-edge interrupt");
  wake_change_a: assert property (
    (wake_all[8] && pin_in[8] != $past(pin_in[8])) ##1 wake_all[8][*2] |=> stop_recover)
    else $error("wake pin change did not start recovery");

  alt_spi_c: cover property (alt_all[19] && pin_oe[19]);
  irq_rise_c: cover property (irq_port_d[0] && irq_rise_sel[8]);
  wake_c: cover property (stop_recover);

endmodule : gpx_top
